/* src/irl_pkg.sv */
/*
 Package for the internal interrupt request latches: register selects,
 field positions, reset values and carrier types.
 Assumes a single processor clock domain and a peripheral register port.
*/
package irl_pkg;

	// Register selects on the peripheral register port
	localparam logic [1:0] IRL_SEL_TIMER  = 2'h0;
	localparam logic [1:0] IRL_SEL_DMA    = 2'h1;
	localparam logic [1:0] IRL_SEL_SERIAL = 2'h2;

	// Field positions: latch bits low, write guard bits from bit 8
	localparam int IRL_GUARD_POS = 8;
	localparam int IRL_TIMER_N   = 3;
	localparam int IRL_DMA_N     = 4;
	localparam int IRL_SERIAL_N  = 4;
	localparam int IRL_SOURCES   = 11;

	// Serial bit order: rx0, tx0, rx1, tx1
	localparam int IRL_SER_RX0 = 0;
	localparam int IRL_SER_TX0 = 1;
	localparam int IRL_SER_RX1 = 2;
	localparam int IRL_SER_TX1 = 3;

	localparam logic [2:0] IRL_TIMER_RST  = 3'h0;
	localparam logic [3:0] IRL_DMA_RST    = 4'h0;
	localparam logic [3:0] IRL_SERIAL_RST = 4'h0;
	localparam logic [15:0] IRL_RDATA_RST = 16'h0000;

	// Peripheral pulse inputs
	typedef struct packed {
		logic [2:0] timer_maxcount_req;
		logic [3:0] dma_done_req;
		logic       serial1_tx_done_req;
		logic       serial1_rx_done_req;
		logic       serial0_tx_done_req;
		logic       serial0_rx_done_req;
	} irl_pulse_t;

	// Register port request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [1:0]  sel;
		logic [15:0] wdata;
	} irl_bus_t;

	// Seven hardwired slave controller inputs
	typedef struct packed {
		logic       serial0_tx;
		logic       serial0_rx;
		logic [1:0] dma_hi;
		logic [2:0] timer;
	} irl_slave_ir_t;

	// Four sources routed to the port 3 multiplexer
	typedef struct packed {
		logic       serial1_tx;
		logic       serial1_rx;
		logic [1:0] dma_lo;
	} irl_mux_out_t;

endpackage

/* src/irl_latches.sv */
/*
 Internal interrupt request latches: turn peripheral request pulses into
 level requests for the slave interrupt controller and the port 3 pins.
 Assumes pulses and register port come from logic on sys_clk_i.
*/
`timescale 1ns/100ps
module irl_latches
(
	input  wire logic                   sys_clk_i,
	input  wire logic                   rst_n_i,
	input  wire logic                   clk_en_i,
	input  wire irl_pkg::irl_pulse_t    pulse_i,
	input  wire irl_pkg::irl_bus_t      bus_i,
	output logic [15:0]                 rdata_o,
	output irl_pkg::irl_slave_ir_t      slave_ir_o,
	output irl_pkg::irl_mux_out_t       mux_irq_o
);
	import irl_pkg::*;

	logic [IRL_TIMER_N-1:0]  timer_latch_bits;
	logic [IRL_DMA_N-1:0]    dma_latch_bits;
	logic [IRL_SERIAL_N-1:0] serial_latch_bits;
	logic [IRL_TIMER_N-1:0]  next_timer;
	logic [IRL_DMA_N-1:0]    next_dma;
	logic [IRL_SERIAL_N-1:0] next_serial;
	logic [IRL_TIMER_N-1:0]  timer_set;
	logic [IRL_DMA_N-1:0]    dma_set;
	logic [IRL_SERIAL_N-1:0] serial_set;
	logic [3:0]              wguard;
	logic [3:0]              wval;

	// Pulses are sampled at each rising edge with clk_en_i high; a one-cycle pulse is seen at exactly one
	assign timer_set  = pulse_i.timer_maxcount_req;
	assign dma_set    = pulse_i.dma_done_req;
	assign serial_set = {pulse_i.serial1_tx_done_req, pulse_i.serial1_rx_done_req,
		pulse_i.serial0_tx_done_req, pulse_i.serial0_rx_done_req};

	// Guards are write only: never stored, so every write must carry them
	assign wguard = bus_i.wdata[IRL_GUARD_POS+3:IRL_GUARD_POS];
	assign wval   = bus_i.wdata[3:0];

	// Guarded write, then hardware set on top so a pulse wins over a clear
	always_comb
	begin
		next_timer  = timer_latch_bits;
		next_dma    = dma_latch_bits;
		next_serial = serial_latch_bits;
		if (bus_i.wr)
		begin
			unique case (bus_i.sel)
				IRL_SEL_TIMER:
				begin
					next_timer = (timer_latch_bits & ~wguard[2:0])
						| (wval[2:0] & wguard[2:0]);
				end
				IRL_SEL_DMA:
				begin
					next_dma = (dma_latch_bits & ~wguard) | (wval & wguard);
				end
				IRL_SEL_SERIAL:
				begin
					next_serial = (serial_latch_bits & ~wguard) | (wval & wguard);
				end
				default:
				begin
					next_timer = timer_latch_bits;
				end
			endcase
		end
		next_timer  = next_timer | timer_set;
		next_dma    = next_dma | dma_set;
		next_serial = next_serial | serial_set;
	end

	// Three identical latch registers, held until cleared
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			timer_latch_bits  <= IRL_TIMER_RST;
			dma_latch_bits    <= IRL_DMA_RST;
			serial_latch_bits <= IRL_SERIAL_RST;
		end
		else if (clk_en_i)
		begin
			timer_latch_bits  <= next_timer;
			dma_latch_bits    <= next_dma;
			serial_latch_bits <= next_serial;
		end
	end

	// Read data registered; guard positions always zero
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rdata_o <= IRL_RDATA_RST;
		end
		else if (clk_en_i && bus_i.rd)
		begin
			unique case (bus_i.sel)
				IRL_SEL_TIMER:  rdata_o <= {13'h0000, timer_latch_bits};
				IRL_SEL_DMA:    rdata_o <= {12'h000, dma_latch_bits};
				IRL_SEL_SERIAL: rdata_o <= {12'h000, serial_latch_bits};
				default:        rdata_o <= IRL_RDATA_RST;
			endcase
		end
	end

	// Outputs follow the latch flops one cycle later, as registers
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			slave_ir_o <= '0;
			mux_irq_o  <= '0;
		end
		else if (clk_en_i)
		begin
			// Fixed wiring order is the default slave priority
			slave_ir_o.timer      <= timer_latch_bits;
			slave_ir_o.dma_hi     <= dma_latch_bits[3:2];
			slave_ir_o.serial0_rx <= serial_latch_bits[IRL_SER_RX0];
			slave_ir_o.serial0_tx <= serial_latch_bits[IRL_SER_TX0];
			mux_irq_o.dma_lo      <= dma_latch_bits[1:0];
			mux_irq_o.serial1_rx  <= serial_latch_bits[IRL_SER_RX1];
			mux_irq_o.serial1_tx  <= serial_latch_bits[IRL_SER_TX1];
		end
	end

	// Count of live requests, only for the checks below
	logic [3:0] live_cnt;
	assign live_cnt = 4'($countones({timer_latch_bits, dma_latch_bits, serial_latch_bits}));

	source_count_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		live_cnt <= 4'(IRL_SOURCES))
		else $error("more live requests than sources");

	pulse_sets_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		clk_en_i && pulse_i.timer_maxcount_req[0] |=> timer_latch_bits[0])
		else $error("timer pulse not latched");

	set_wins_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		clk_en_i && pulse_i.serial0_rx_done_req && bus_i.wr && bus_i.sel == IRL_SEL_SERIAL
		|=> serial_latch_bits[IRL_SER_RX0])
		else $error("pulse lost to clear");

	hold_level_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		timer_latch_bits[1] && !(bus_i.wr && bus_i.sel == IRL_SEL_TIMER) |=> timer_latch_bits[1])
		else $error("latch dropped without write");

	guard_off_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		clk_en_i && bus_i.wr && bus_i.sel == IRL_SEL_DMA && !bus_i.wdata[IRL_GUARD_POS+2]
		&& !pulse_i.dma_done_req[2] |=> $stable(dma_latch_bits[2]))
		else $error("unguarded bit changed");

	guard_read_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		rdata_o[15:4] == 12'h000)
		else $error("guard positions read nonzero");

	wired_out_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		clk_en_i |=> slave_ir_o.timer == $past(timer_latch_bits))
		else $error("slave input not following latch");

	mux_pin_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		clk_en_i && bus_i.wr && bus_i.sel == IRL_SEL_DMA && bus_i.wdata[IRL_GUARD_POS]
		&& bus_i.wdata[0] ##1 clk_en_i |=> mux_irq_o.dma_lo[0])
		else $error("software set did not reach pin");

	// Per-bit views for the checks: guarded write hits and output pins by bit
	logic [IRL_TIMER_N-1:0]  timer_hit;
	logic [IRL_DMA_N-1:0]    dma_hit;
	logic [IRL_SERIAL_N-1:0] serial_hit;
	logic [IRL_DMA_N-1:0]    dma_view;
	logic [IRL_SERIAL_N-1:0] serial_view;
	assign timer_hit   = wguard[2:0] & {IRL_TIMER_N{bus_i.wr && bus_i.sel == IRL_SEL_TIMER}};
	assign dma_hit     = wguard & {IRL_DMA_N{bus_i.wr && bus_i.sel == IRL_SEL_DMA}};
	assign serial_hit  = wguard & {IRL_SERIAL_N{bus_i.wr && bus_i.sel == IRL_SEL_SERIAL}};
	assign dma_view    = {slave_ir_o.dma_hi, mux_irq_o.dma_lo};
	assign serial_view = {mux_irq_o.serial1_tx, mux_irq_o.serial1_rx,
		slave_ir_o.serial0_tx, slave_ir_o.serial0_rx};

	// Timer bits: set by pulse, changed only by guarded write
	for (genvar g = 0; g < IRL_TIMER_N; g++)
	begin : gen_timer_chk
		tmr_set_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
			clk_en_i && timer_set[g] |=> timer_latch_bits[g])
			else $error("timer bit not set by pulse");

		tmr_keep_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
			clk_en_i && !timer_set[g] && !timer_hit[g] |=> $stable(timer_latch_bits[g]))
			else $error("timer bit changed without cause");

		tmr_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
			clk_en_i && timer_hit[g] && !wval[g] && !timer_set[g] |=> !timer_latch_bits[g])
			else $error("timer bit not cleared");

		tmr_inject_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
			clk_en_i && timer_hit[g] && wval[g] |=> timer_latch_bits[g])
			else $error("timer bit not set by software");

		tmr_load_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
			clk_en_i && timer_hit[g] && !timer_set[g] |=> timer_latch_bits[g] == $past(wval[g]))
			else $error("timer bit not loaded");

		tmr_wire_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
			clk_en_i |=> slave_ir_o.timer[g] == $past(timer_latch_bits[g]))
			else $error("timer request not wired");

		tmr_reach_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
			clk_en_i && timer_set[g] ##1 clk_en_i |=> slave_ir_o.timer[g])
			else $error("timer pulse not reaching controller");

		tmr_quiet_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
			clk_en_i && !timer_latch_bits[g] && !timer_set[g] && !(timer_hit[g] && wval[g])
			|=> !timer_latch_bits[g])
			else $error("timer bit set without source");
	end

	// DMA bits: channels 2 and 3 wired in, 0 and 1 out to the pins
	for (genvar g = 0; g < IRL_DMA_N; g++)
	begin : gen_dma_chk
		dma_set_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
			clk_en_i && dma_set[g] |=> dma_latch_bits[g])
			else $error("dma bit not set by pulse");

		dma_keep_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
			clk_en_i && !dma_set[g] && !dma_hit[g] |=> $stable(dma_latch_bits[g]))
			else $error("dma bit changed without cause");

		dma_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
			clk_en_i && dma_hit[g] && !wval[g] && !dma_set[g] |=> !dma_latch_bits[g])
			else $error("dma bit not cleared");

		dma_inject_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
			clk_en_i && dma_hit[g] && wval[g] |=> dma_latch_bits[g])
			else $error("dma bit not set by software");

		dma_load_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
			clk_en_i && dma_hit[g] && !dma_set[g] |=> dma_latch_bits[g] == $past(wval[g]))
			else $error("dma bit not loaded");

		dma_wire_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
			clk_en_i |=> dma_view[g] == $past(dma_latch_bits[g]))
			else $error("dma request not routed");

		dma_reach_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
			clk_en_i && dma_set[g] ##1 clk_en_i |=> dma_view[g])
			else $error("dma pulse not reaching output");

		dma_quiet_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
			clk_en_i && !dma_latch_bits[g] && !dma_set[g] && !(dma_hit[g] && wval[g])
			|=> !dma_latch_bits[g])
			else $error("dma bit set without source");
	end

	// Serial bits: channel 0 wired in, channel 1 out to the pins
	for (genvar g = 0; g < IRL_SERIAL_N; g++)
	begin : gen_serial_chk
		ser_set_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
			clk_en_i && serial_set[g] |=> serial_latch_bits[g])
			else $error("serial bit not set by pulse");

		ser_keep_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
			clk_en_i && !serial_set[g] && !serial_hit[g] |=> $stable(serial_latch_bits[g]))
			else $error("serial bit changed without cause");

		ser_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
			clk_en_i && serial_hit[g] && !wval[g] && !serial_set[g] |=> !serial_latch_bits[g])
			else $error("serial bit not cleared");

		ser_inject_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
			clk_en_i && serial_hit[g] && wval[g] |=> serial_latch_bits[g])
			else $error("serial bit not set by software");

		ser_load_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
			clk_en_i && serial_hit[g] && !serial_set[g] |=> serial_latch_bits[g] == $past(wval[g]))
			else $error("serial bit not loaded");

		ser_wire_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
			clk_en_i |=> serial_view[g] == $past(serial_latch_bits[g]))
			else $error("serial request not routed");

		ser_reach_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
			clk_en_i && serial_set[g] ##1 clk_en_i |=> serial_view[g])
			else $error("serial pulse not reaching output");

		ser_quiet_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
			clk_en_i && !serial_latch_bits[g] && !serial_set[g] && !(serial_hit[g] && wval[g])
			|=> !serial_latch_bits[g])
			else $error("serial bit set without source");
	end

	// Reads show the latch state before a same-cycle write
	rd_timer_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		clk_en_i && bus_i.rd && bus_i.sel == IRL_SEL_TIMER
		|=> rdata_o == {13'h0000, $past(timer_latch_bits)})
		else $error("timer read wrong");

	rd_dma_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		clk_en_i && bus_i.rd && bus_i.sel == IRL_SEL_DMA
		|=> rdata_o == {12'h000, $past(dma_latch_bits)})
		else $error("dma read wrong");

	rd_serial_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		clk_en_i && bus_i.rd && bus_i.sel == IRL_SEL_SERIAL
		|=> rdata_o == {12'h000, $past(serial_latch_bits)})
		else $error("serial read wrong");

	rd_unmapped_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		clk_en_i && bus_i.rd && bus_i.sel == 2'h3 |=> rdata_o == IRL_RDATA_RST)
		else $error("unmapped read not zero");

	rd_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!(clk_en_i && bus_i.rd) |=> $stable(rdata_o))
		else $error("read data changed without read");

	// Enable low must freeze every flop, outputs included
	freeze_all_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!clk_en_i |=> $stable(timer_latch_bits) && $stable(dma_latch_bits)
		&& $stable(serial_latch_bits) && $stable(slave_ir_o) && $stable(mux_irq_o))
		else $error("state moved while disabled");

	unmapped_wr_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		clk_en_i && bus_i.wr && bus_i.sel == 2'h3 && pulse_i == '0
		|=> $stable(timer_latch_bits) && $stable(dma_latch_bits) && $stable(serial_latch_bits))
		else $error("unmapped write changed a latch");

	level_out_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		clk_en_i && (|{timer_latch_bits, dma_latch_bits, serial_latch_bits})
		|=> (|slave_ir_o) || (|mux_irq_o))
		else $error("live request not presented");

endmodule

/* verif/irl_far_end.sv */
/*
 Far-end model: the slave controller inputs plus the board wiring that
 feeds the four multiplexed request pins back to external inputs.
 Assumes level requests from the latch block.
*/
`timescale 1ns/100ps
module irl_far_end
(
	input  wire irl_pkg::irl_slave_ir_t slave_ir_i,
	input  wire irl_pkg::irl_mux_out_t  mux_irq_i,
	output logic                        irq_o
);
	import irl_pkg::*;
	// Without this loop-back the four routed sources never interrupt
	assign irq_o = (|slave_ir_i) || (|mux_irq_i);
endmodule

/* verif/tb_irl_latches.sv */
/*
 Bench for the request latches: random pulses and guarded register
 traffic compared with an integer model. Assumes irl_far_end beside it.
*/
`timescale 1ns/100ps
module tb_irl_latches;
	import irl_pkg::*;
	logic          sys_clk_i = 1'b0;
	logic          rst_n_i = 1'b0;
	logic          clk_en_i = 1'b0;
	irl_pulse_t    pulse_i = '0;
	irl_bus_t      bus_i = '0;
	logic [15:0]   rdata_o;
	irl_slave_ir_t slave_ir_o;
	irl_mux_out_t  mux_irq_o;
	logic          any_irq;
	int            bad_count = 0;
	int            n_tests = 0;
	int            cycles = 0;
	int            seed = 52625;
	int            lt[3];
	int            rd_exp;
	irl_latches uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
		.pulse_i(pulse_i), .bus_i(bus_i), .rdata_o(rdata_o), .slave_ir_o(slave_ir_o),
		.mux_irq_o(mux_irq_o));
	irl_far_end far (.slave_ir_i(slave_ir_o), .mux_irq_i(mux_irq_o), .irq_o(any_irq));
	initial
	begin
		forever #2 sys_clk_i = ~sys_clk_i;
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge sys_clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			bad_count++;
			wrap_up();
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One request, then one idle edge so outputs have settled
	task automatic step(input irl_pulse_t p, input logic en, input irl_bus_t b);
		int s;
		int g;
		@(posedge sys_clk_i);
		pulse_i <= p;
		clk_en_i <= en;
		bus_i <= b;
		@(posedge sys_clk_i);
		pulse_i <= '0;
		bus_i <= '0;
		clk_en_i <= 1'b1;
		if (en)
		begin
			s = b.sel;
			g = b.wdata[11:8];
			if (b.rd)
				rd_exp = (s == 3) ? 0 : lt[s];
			if (b.wr && s != 3)
				lt[s] = (lt[s] & ~g) | (b.wdata[3:0] & g);
			// Set applied after clear so a colliding pulse wins
			lt[0] |= p.timer_maxcount_req;
			lt[1] |= p.dma_done_req;
			lt[2] |= {p.serial1_tx_done_req, p.serial1_rx_done_req,
				p.serial0_tx_done_req, p.serial0_rx_done_req};
		end
		@(posedge sys_clk_i);
		#1;
		chk(rdata_o, rd_exp);
		chk(slave_ir_o, {lt[2][1:0], lt[1][3:2], lt[0][2:0]});
		chk(mux_irq_o, {lt[2][3:2], lt[1][1:0]});
		chk(any_irq, (lt[0] | lt[1] | lt[2]) != 0);
	endtask
	initial
	begin
		irl_bus_t   b;
		irl_pulse_t p;
		lt = '{0, 0, 0};
		rd_exp = 0;
		repeat (2)
		begin
			rst_n_i <= 1'b0;
			repeat (4) @(posedge sys_clk_i);
			rst_n_i <= 1'b1;
			lt = '{0, 0, 0};
			rd_exp = 0;
			for (int i = 0; i < 4; i++)
				step('0, 1'b1, '{wr: 1'b0, rd: 1'b1, sel: 2'(i), wdata: 16'h0000});
			p = '{timer_maxcount_req: 3'h1, default: '0};
			b = '{wr: 1'b1, rd: 1'b1, sel: IRL_SEL_TIMER, wdata: 16'h0100};
			step(p, 1'b1, '0);
			step(p, 1'b1, b);
			step('0, 1'b1, b);
			repeat (300)
			begin
				p = 11'($random(seed) & $random(seed));
				b = 20'($random(seed));
				b.wdata &= (b.sel == IRL_SEL_TIMER) ? 16'h0707 : 16'h0F0F;
				step(p, ($random(seed) & 7) != 0, b);
			end
		end
		wrap_up();
	end
endmodule
